// File: rtl/addr_opt_pkg.sv
// Constants for the ROM mirror, address trim and pull option decode
package addr_opt_pkg;
	localparam int          ADDR_W        = 24;
	localparam int          EXT_ADDR_W    = 20;
	localparam int          OPT_BYTES     = 12;
	localparam int          OPT_IDX_W     = 4;
	localparam int          PORT_COUNT    = 11;
	localparam logic [7:0]  BANK_ROM      = 8'hff;
	localparam logic [7:0]  BANK_ZERO     = 8'h00;
	localparam logic [15:0] MIRROR_BASE   = 16'h4000;
	localparam logic [3:0]  OPT_STEP      = 4'h4;
	localparam int          BIT_RST_UP    = 6;
	localparam int          BIT_MODE1_UP  = 4;
	localparam int          BIT_MODE1_DN  = 3;
	localparam int          BIT_MODE0_UP  = 2;
	localparam int          BIT_MODE0_DN  = 1;
	localparam logic [7:0]  OPT_BLANK     = 8'hff;
	localparam logic [31:0] AXI_ADDR_BASE = 32'h0000_0000;
	localparam logic [31:0] PULL_STAT_OFS = 32'h0000_0000;
	localparam logic [31:0] PORT_STAT_OFS = 32'h0000_0004;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// Vacant bit masks per option byte (1 = implemented)
	localparam logic [7:0]  MASK_BYTE0    = 8'h5e;
	localparam logic [7:0]  MASK_PORT8    = 8'h7f;
	localparam logic [7:0]  MASK_PORTA_LO = 8'hfc;
	localparam logic [7:0]  MASK_PORTB    = 8'h1f;
endpackage

// File: rtl/addr_opt.sv
// Address mirror/trim and one-time option pull resistor decode
// Behaviour
// RULE_01 - Option bit one disables, zero enables
// RULE_02 - Byte zero holds reset and mode pulls
// RULE_03 - One port per byte, stepping by four
// RULE_04 - Programmer writes one into reserved bits
// RULE_05 - Small variant programs ones for extended ports
// RULE_06 - Bank FF ROM readable in bank 00
// RULE_07 - Large ROM mirrors only from FF4000
// RULE_08 - Top four address bits not driven out
// RULE_09 - Software uses at most sixteen banks
// RULE_10 - Options latched at reset, held after
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module addr_opt
	import addr_opt_pkg::*;
(
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// Variant straps
	input  wire logic                          large_rom,
	input  wire logic                          large_pkg,
	// Option store read port
	output logic [addr_opt_pkg::OPT_IDX_W-1:0] opt_index,
	input  wire logic [7:0]                    opt_data,
	// CPU address side
	input  wire logic [addr_opt_pkg::ADDR_W-1:0] cpu_addr,
	input  wire logic                          cpu_req,
	output logic                               rom_sel,
	output logic [15:0]                        rom_offset,
	output logic                               ext_sel,
	output logic [addr_opt_pkg::EXT_ADDR_W-1:0] ext_addr,
	// Pull resistor enables
	output logic                               rst_pullup_en,
	output logic                               mode_pin_one_pullup_en,
	output logic                               mode_pin_one_pulldown_en,
	output logic                               mode_pin_zero_pullup_en,
	output logic                               mode_pin_zero_pulldown_en,
	output logic [addr_opt_pkg::PORT_COUNT*8-1:0] port_pullup_en,
	output logic                               opt_done,
	// AXI4-Lite write address
	input  wire logic [31:0]                   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]                   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	import addr_opt_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_DONE = 3'b100
	} load_st_t;

	// Straps come from pins: two stages before use
	logic [1:0]              rom_sync_ff, pkg_sync_ff;
	logic [1:0]              nxt_rom_sync, nxt_pkg_sync;
	logic                    large_rom_ff, large_pkg_ff;
	logic                    nxt_large_rom, nxt_large_pkg;
	load_st_t                st_ff, nxt_st;
	logic [OPT_IDX_W-1:0]    idx_ff, nxt_idx;
	logic [7:0]              opt_ff [OPT_BYTES];
	logic [7:0]              nxt_opt [OPT_BYTES];
	logic [7:0]              eff [OPT_BYTES];

	always_comb
	begin
		nxt_rom_sync = {rom_sync_ff[0], large_rom};
		nxt_pkg_sync = {pkg_sync_ff[0], large_pkg};
		nxt_large_rom = large_rom_ff;
		nxt_large_pkg = large_pkg_ff;
		nxt_st = st_ff;
		nxt_idx = idx_ff;
		for (int i = 0; i < OPT_BYTES; i++)
			nxt_opt[i] = opt_ff[i];
		unique case (st_ff)
			ST_IDLE:
			begin
				// Straps caught after release, once synchronised
				nxt_large_rom = rom_sync_ff[1];
				nxt_large_pkg = pkg_sync_ff[1];
				nxt_st = ST_LOAD;
			end
			ST_LOAD:
			begin
				// Store answers combinationally for the index
				nxt_opt[idx_ff] = opt_data; // RULE_03
				if (idx_ff == OPT_IDX_W'(OPT_BYTES - 1))
					nxt_st = ST_DONE;
				else
					nxt_idx = idx_ff + OPT_IDX_W'(1);
			end
			ST_DONE:
				nxt_st = ST_DONE; // RULE_10
		endcase
	end

	// No reset: straps are sampled while reset is still held
	always_ff @(posedge aclk)
	begin
		rom_sync_ff <= nxt_rom_sync;
		pkg_sync_ff <= nxt_pkg_sync;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			large_rom_ff <= 1'b0;
			large_pkg_ff <= 1'b0;
			st_ff <= ST_IDLE;
			idx_ff <= '0;
			for (int i = 0; i < OPT_BYTES; i++)
				opt_ff[i] <= OPT_BLANK; // RULE_10
		end
		else
		begin
			large_rom_ff <= nxt_large_rom;
			large_pkg_ff <= nxt_large_pkg;
			st_ff <= nxt_st;
			idx_ff <= nxt_idx;
			for (int i = 0; i < OPT_BYTES; i++)
				opt_ff[i] <= nxt_opt[i];
		end
	end

	// Byte address = index * step; store is byte-indexed by entry
	assign opt_index = idx_ff;
	assign opt_done  = (st_ff == ST_DONE);

	// Vacant bits forced to one so they never enable a resistor
	always_comb
	begin
		for (int i = 0; i < OPT_BYTES; i++)
			eff[i] = opt_ff[i]; // RULE_04
		eff[0] = opt_ff[0] | ~MASK_BYTE0;
		eff[9] = opt_ff[9] | ~MASK_PORT8;
		eff[10] = opt_ff[10] | ~MASK_PORTA_LO;
		eff[11] = opt_ff[11] | ~MASK_PORTB;
		// Entry six lists no pins: kept off
		eff[6] = OPT_BLANK; // RULE_04
		// Small package: extended port options unimplemented
		if (!large_pkg_ff)
		begin
			eff[9] = opt_ff[9] | 8'hfe; // RULE_05
			eff[10] = OPT_BLANK;
			eff[11] = OPT_BLANK;
		end
		// Until loaded, all resistors stay off
		if (st_ff != ST_DONE)
			for (int i = 0; i < OPT_BYTES; i++)
				eff[i] = OPT_BLANK;
	end

	assign rst_pullup_en = ~eff[0][BIT_RST_UP]; // RULE_02 RULE_01
	assign mode_pin_one_pullup_en    = ~eff[0][BIT_MODE1_UP]; // RULE_02
	assign mode_pin_one_pulldown_en  = ~eff[0][BIT_MODE1_DN]; // RULE_02
	assign mode_pin_zero_pullup_en   = ~eff[0][BIT_MODE0_UP]; // RULE_02
	assign mode_pin_zero_pulldown_en = ~eff[0][BIT_MODE0_DN]; // RULE_02

	// Byte k (k>=1) steers port slot k-1; bit n drives pin n
	genvar g;
	generate
		for (g = 0; g < PORT_COUNT; g++)
		begin : g_port
			assign port_pullup_en[g*8 +: 8] = ~eff[g+1]; // RULE_03 RULE_01
		end
	endgenerate

	// Address path
	logic [7:0]  bank;
	logic [15:0] low;
	logic        in_mirror;
	assign bank = cpu_addr[23:16];
	assign low  = cpu_addr[15:0];
	always_comb
	begin
		// Bank 00 top half only; large ROM starts lower, at 4000
		in_mirror = (bank == BANK_ZERO) && low[15]; // RULE_06
		if (large_rom_ff)
			in_mirror = (bank == BANK_ZERO) && (low >= MIRROR_BASE); // RULE_07
		rom_sel = cpu_req && ((bank == BANK_ROM) || in_mirror); // RULE_06
		ext_sel = cpu_req && !rom_sel;
	end
	assign rom_offset = low; // RULE_06
	// Upper four bits dropped: banks alias on the external bus
	assign ext_addr = cpu_addr[EXT_ADDR_W-1:0]; // RULE_08 RULE_09

	// AXI4-Lite slave: read-only status, writes answered SLVERR
	logic        aw_ff, w_ff, bv_ff, rv_ff;
	logic        nxt_aw, nxt_w, nxt_bv, nxt_rv;
	logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [31:0] rd_ofs;
	logic [31:0] stat_word, idx_word;

	assign s_axi_awready = !aw_ff && !bv_ff;
	assign s_axi_wready  = !w_ff && !bv_ff;
	assign s_axi_arready = !rv_ff;
	assign rd_ofs = s_axi_araddr - AXI_ADDR_BASE;

	// Status word: load state, straps, then the five pin enables
	always_comb
	begin
		stat_word = {24'h0, opt_done, large_pkg_ff, large_rom_ff,
			mode_pin_zero_pulldown_en, mode_pin_zero_pullup_en,
			mode_pin_one_pulldown_en, mode_pin_one_pullup_en,
			rst_pullup_en}; // RULE_02
	end
	// Stops at the last entry once loading ends
	assign idx_word = {28'h0, idx_ff};

	always_comb
	begin
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_bv = bv_ff;
		nxt_bresp = bresp_ff;
		nxt_rv = rv_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_awvalid && s_axi_awready)
			nxt_aw = 1'b1;
		if (s_axi_wvalid && s_axi_wready)
			nxt_w = 1'b1;
		if (nxt_aw && nxt_w && !bv_ff)
		begin
			// Options are fixed until reset: nothing to write
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_bv = 1'b1;
			nxt_bresp = RESP_SLVERR;
		end
		if (bv_ff && s_axi_bready)
			nxt_bv = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_rv = 1'b1;
			nxt_rresp = RESP_OKAY;
			if (rd_ofs == PULL_STAT_OFS)
				nxt_rdata = stat_word;
			else if (rd_ofs == PORT_STAT_OFS)
				nxt_rdata = idx_word;
			else
			begin
				nxt_rdata = 32'h0;
				nxt_rresp = RESP_SLVERR;
			end
		end
		else if (rv_ff && s_axi_rready)
			nxt_rv = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			bv_ff <= 1'b0;
			rv_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0;
		end
		else
		begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			bv_ff <= nxt_bv;
			rv_ff <= nxt_rv;
			bresp_ff <= nxt_bresp;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	assign s_axi_bvalid = bv_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rv_ff;
	assign s_axi_rresp  = rresp_ff;
	assign s_axi_rdata  = rdata_ff;
endmodule // addr_opt
`default_nettype wire

// File: bench/addr_opt_checker.sv
// Port-level assertions for the address mirror and pull option block
`timescale 1ns/1ns
`default_nettype none
module addr_opt_checker
	import addr_opt_pkg::*;
(
	// Clock and reset
	input wire logic                                aclk,
	input wire logic                                aresetn,
	// Strap and CPU side
	input wire logic                                large_rom,
	input wire logic [addr_opt_pkg::ADDR_W-1:0]     cpu_addr,
	input wire logic                                cpu_req,
	input wire logic                                rom_sel,
	input wire logic [15:0]                         rom_offset,
	input wire logic                                ext_sel,
	input wire logic [addr_opt_pkg::EXT_ADDR_W-1:0] ext_addr,
	// Pull enables
	input wire logic                                rst_pullup_en,
	input wire logic [addr_opt_pkg::PORT_COUNT*8-1:0] port_pullup_en,
	input wire logic                                opt_done,
	// Write response
	input wire logic                                s_axi_bvalid,
	input wire logic [1:0]                          s_axi_bresp
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic b0 = cpu_req && cpu_addr[23:16] == BANK_ZERO;
	AST_TRIM: assert property (ext_addr == cpu_addr[19:0]) else $error("ext addr");
	AST_BANKFF: assert property (cpu_req && cpu_addr[23:16] == BANK_ROM |-> rom_sel && rom_offset == cpu_addr[15:0]) else $error("bank ff");
	AST_MIRROR: assert property (b0 && cpu_addr[15] |-> rom_sel && !ext_sel) else $error("mirror");
	AST_LARGE: assert property (opt_done && large_rom && b0 && cpu_addr[15:14] == 2'b01 |-> rom_sel) else $error("large mirror");
	AST_SMALL: assert property (opt_done && !large_rom && b0 && !cpu_addr[15] |-> ext_sel) else $error("small mirror");
	AST_OTHER: assert property (cpu_req && cpu_addr[23:16] != BANK_ROM && cpu_addr[23:16] != BANK_ZERO |-> ext_sel && !rom_sel) else $error("alias");
	AST_HOLD: assert property (opt_done |=> opt_done && $stable(port_pullup_en) && $stable(rst_pullup_en)) else $error("hold");
	AST_QUIET: assert property (!opt_done |-> port_pullup_en == '0 && !rst_pullup_en) else $error("early");
	AST_LOAD: assert property ($rose(aresetn) |-> ##[1:16] opt_done) else $error("load");
	AST_BERR: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_SLVERR) else $error("bresp");
	cover property (b0 && rom_sel);
	cover property (s_axi_bvalid);
	cover property ($rose(opt_done));
endmodule // addr_opt_checker
`default_nettype wire

// File: bench/opt_store_model.sv
// Behavioural one-time option store read by index
`timescale 1ns/1ns
`default_nettype none
module opt_store_model
	import addr_opt_pkg::*;
(
	// Programmed image and read port
	input  wire logic [95:0] image,
	input  wire logic [3:0]  opt_index,
	output logic [7:0]       opt_data
);
	// Unprogrammed places read as erased ones
	assign opt_data = (opt_index < 4'(OPT_BYTES)) ?
		image[{opt_index, 3'b000}+:8] : OPT_BLANK;
endmodule // opt_store_model
`default_nettype wire

// File: bench/addr_opt_tb.sv
// Self-checking bench for the address mirror and pull option block
`timescale 1ns/1ns
`default_nettype none
module addr_opt_tb;
	import addr_opt_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, large_rom = 1'b0;
	logic        large_pkg = 1'b0, cpu_req = 1'b0;
	logic [23:0] cpu_addr = 24'h0, a;
	logic [95:0] image = '1;
	logic [3:0]  opt_index, s_axi_wstrb = 4'hf;
	logic [7:0]  opt_data;
	logic [15:0] rom_offset;
	logic [19:0] ext_addr;
	logic [87:0] port_pullup_en;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        rom_sel, ext_sel, opt_done, rst_pullup_en;
	logic        mode_pin_one_pullup_en, mode_pin_one_pulldown_en;
	logic        mode_pin_zero_pullup_en, mode_pin_zero_pulldown_en;
	logic [23:0] corner [6] = '{24'h003fff, 24'h004000, 24'h007fff,
		24'h008000, 24'ha00000, 24'hff0000};
	int          errors = 0, total_checks = 0, seed;
	addr_opt addr_opt_inst (
		.aclk(aclk), .aresetn(aresetn), .large_rom(large_rom),
		.large_pkg(large_pkg), .opt_index(opt_index), .opt_data(opt_data),
		.cpu_addr(cpu_addr), .cpu_req(cpu_req), .rom_sel(rom_sel),
		.rom_offset(rom_offset), .ext_sel(ext_sel), .ext_addr(ext_addr),
		.rst_pullup_en(rst_pullup_en),
		.mode_pin_one_pullup_en(mode_pin_one_pullup_en),
		.mode_pin_one_pulldown_en(mode_pin_one_pulldown_en),
		.mode_pin_zero_pullup_en(mode_pin_zero_pullup_en),
		.mode_pin_zero_pulldown_en(mode_pin_zero_pulldown_en),
		.port_pullup_en(port_pullup_en), .opt_done(opt_done),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	opt_store_model opt_store_model_inst (
		.image(image), .opt_index(opt_index), .opt_data(opt_data));
	always #20 aclk = ~aclk;
	function automatic logic [7:0] used(input int i, input logic pkg);
		case (i)
			0: used = MASK_BYTE0;
			6: used = 8'h00;
			9: used = pkg ? MASK_PORT8 : 8'h01;
			10: used = pkg ? MASK_PORTA_LO : 8'h00;
			11: used = pkg ? MASK_PORTB : 8'h00;
			default: used = 8'hff;
		endcase
	endfunction
	function automatic logic exp_rom(input logic [23:0] x, input logic big);
		exp_rom = x[23:16] == BANK_ROM ||
			(x[23:16] == BANK_ZERO && (x[15] || (big && x[14])));
	endfunction
	task automatic chk(input string n, input logic [87:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic axr(input logic [31:0] ad);
		@(posedge aclk);
		s_axi_araddr <= ad;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		// Handshakes looked at mid-cycle, where they are settled
		@(negedge aclk);
		while (s_axi_arready !== 1'b1) @(negedge aclk);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(negedge aclk);
		while (s_axi_rvalid !== 1'b1) @(negedge aclk);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic axw(input logic [31:0] ad);
		logic at, dt, ta, td;
		at = 1'b0;
		dt = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= $random(seed);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(at && dt))
		begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			td = s_axi_wvalid & s_axi_wready;
			@(posedge aclk);
			at = at | ta;
			dt = dt | td;
			if (ta) s_axi_awvalid <= 1'b0;
			if (td) s_axi_wvalid <= 1'b0;
		end
		@(negedge aclk);
		while (s_axi_bvalid !== 1'b1) @(negedge aclk);
		rr = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	initial
	begin
		#400000;
		errors++;
		end_sim;
	end
	initial
	begin
		seed = 32'h131f;
		for (int v = 0; v < 4; v++)
		begin
			@(posedge aclk);
			aresetn <= 1'b0;
			large_rom <= v[0];
			large_pkg <= v[1];
			for (int i = 0; i < 12; i++)
				image[i*8+:8] <= 8'($random(seed)) |
					~used(i, v[1]);
			repeat (4) @(posedge aclk);
			aresetn <= 1'b1;
			for (int t = 0; t < 20 && opt_done !== 1'b1; t++) @(posedge aclk);
			@(negedge aclk);
			chk("done", opt_done, 1'b1);
			for (int k = 0; k < 11; k++)
				chk("port", port_pullup_en[k*8+:8],
					8'(~image[k*8+8+:8]));
			chk("pin", {rst_pullup_en, mode_pin_one_pullup_en,
				mode_pin_one_pulldown_en, mode_pin_zero_pullup_en,
				mode_pin_zero_pulldown_en},
				5'(~{image[6], image[4:1]}));
			axw(AXI_ADDR_BASE + PULL_STAT_OFS);
			chk("bresp", rr, RESP_SLVERR);
			axr(AXI_ADDR_BASE + PULL_STAT_OFS);
			chk("stat", {rr, rd[7:0]}, {RESP_OKAY, 1'b1, v[1], v[0],
				~image[1], ~image[2], ~image[3], ~image[4], ~image[6]});
			axr(AXI_ADDR_BASE + 32'h8);
			chk("unmapped", {rr, rd}, {RESP_SLVERR, 32'h0});
			axr(AXI_ADDR_BASE + PORT_STAT_OFS);
			chk("index", {rr, rd}, {RESP_OKAY, 32'(OPT_BYTES - 1)});
			for (int n = 0; n < 60; n++)
			begin
				a = (n < 6) ? corner[n] : {(n % 3 == 0) ? BANK_ROM :
					(n % 3 == 1) ? BANK_ZERO : 8'($random(seed)),
					16'($random(seed))};
				@(posedge aclk);
				cpu_req <= 1'b1;
				cpu_addr <= a;
				@(negedge aclk);
				chk("route", {rom_sel, ext_sel, rom_offset, ext_addr},
					{exp_rom(a, v[0]), !exp_rom(a, v[0]), a[15:0],
					a[19:0]});
			end
			@(posedge aclk);
			cpu_req <= 1'b0;
			@(negedge aclk);
			chk("idle", ext_sel, 1'b0);
		end
		end_sim;
	end
endmodule // addr_opt_tb
bind addr_opt addr_opt_checker addr_opt_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .large_rom(large_rom),
	.cpu_addr(cpu_addr), .cpu_req(cpu_req), .rom_sel(rom_sel),
	.rom_offset(rom_offset), .ext_sel(ext_sel), .ext_addr(ext_addr),
	.rst_pullup_en(rst_pullup_en), .port_pullup_en(port_pullup_en),
	.opt_done(opt_done), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bresp(s_axi_bresp));
`default_nettype wire
